// [uhfs_cmp_model.sv]
// Stand-in for the oscillator, ramp and current comparators of the sequencer.
// Assumes one reference clock; the current sense follows the upper gate enable.
`timescale 1ns/1ns
`default_nettype none
module uhfs_cmp_model #(
    parameter int PERIOD = 40
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_upper_gate_drive,
    input wire logic i_good,
    input wire logic i_oc_on,
    output logic o_osc,
    output logic o_ramp90,
    output logic o_oc,
    output logic o_pwm_end
);
    int cnt;
    always @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        end
    end
    // Low line means the ramp never reaches 90% before the next pulse
    assign o_osc = (cnt < 3);
    assign o_ramp90 = i_good && (cnt >= 20);
    assign o_pwm_end = (cnt >= 30);
    // Sense voltage only means anything while the upper switch conducts
    assign o_oc = i_oc_on && i_upper_gate_drive;
endmodule
`default_nettype wire

// [uhfs_pkg.sv]
// Constants, field layouts and carrier types of the protection sequencer.
// Assumes a 100 MHz i_ref_clk and a 32-bit AXI4-Lite register bus.
package uhfs_pkg;
    localparam int CNT_W = 3;
    localparam logic [2:0] CNT_MAX = 3'h7;
    localparam logic [2:0] CNT_SEVEN = 3'h7;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_NS = 100;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BLANK_LAST = 4'(BLANK_CYC - 1);
    localparam logic [2:0] OFF_CYC_LAST = 3'h6;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
    localparam logic CTRL_RESET = 1'b1;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Synchronised comparator inputs, one bit each
    typedef struct packed {
        logic osc;
        logic ramp90;
        logic sync;
        logic oc;
        logic pwm_end;
    } uhfs_cmp_t;
    // Interrupt events, same layout in status, clear and enable
    typedef struct packed {
        logic hiccup;
        logic oc;
        logic pg;
        logic uv;
    } uhfs_evt_t;
    typedef enum logic [1:0] {
        ST_LOCK,
        ST_RUN,
        ST_HICCUP
    } uhfs_state_t;
endpackage

// [uhfs_satcnt.sv]
// Saturating up/down counter used for the line and fault filters.
// Assumes increment and decrement are same-clock single-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module uhfs_satcnt #(
    parameter int W = 3
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_clr,
    input wire logic i_inc,
    input wire logic i_dec,
    output logic [W-1:0] o_count
);
    wire at_max = &o_count;
    wire at_min = ~|o_count;
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_count <= '0;
        end else if (i_clr) begin
            o_count <= '0;
        end else if (i_inc && !at_max) begin
            o_count <= o_count + W'(1);
        end else if (i_dec && !i_inc && !at_min) begin
            o_count <= o_count - W'(1);
        end
    end
endmodule
`default_nettype wire

// [uhfs_sync.sv]
// Three-stage input synchroniser with agreement filter, one per bit.
// Assumes asynchronous inputs from analog comparators or pins.
`timescale 1ns/1ns
`default_nettype none
module uhfs_sync #(
    parameter int W = 5
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge i_ref_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    o_sync[g] <= 1'b0;
                end else begin
                    s1 <= i_async[g];
                    s2 <= s1;
                    s3 <= s2;
                    // A change counts only once two later stages agree
                    if (s2 == s3) begin
                        o_sync[g] <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [uhfs_top.sv]
// Low-line lockout and hiccup overcurrent sequencer with AXI4-Lite registers.
// Assumes comparator outputs arrive asynchronously and gate drivers follow
// the enables directly; the analog ramp and soft-start current are outside.
`timescale 1ns/1ns
`default_nettype none
module uhfs_top (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_osc_clk_pulse,
    input wire logic i_ramp_at_90pct,
    input wire logic i_ext_sync_pulse,
    input wire logic i_overcurrent_trip,
    input wire logic i_pwm_duty_end,
    output logic o_upper_gate_drive,
    output logic o_lower_gate_drive,
    output logic o_softstart_shutdown_node,
    output logic o_power_good,
    output logic o_ramp_restart,
    output logic o_irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detection
    uhfs_pkg::uhfs_cmp_t cmp;
    uhfs_pkg::uhfs_cmp_t cmp_d;
    uhfs_sync #(
        .W(5)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_async({i_osc_clk_pulse, i_ramp_at_90pct, i_ext_sync_pulse,
                  i_overcurrent_trip, i_pwm_duty_end}),
        .o_sync(cmp)
    );
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cmp_d <= '0;
        end else begin
            cmp_d <= cmp;
        end
    end
    wire cyc_start = cmp.osc && !cmp_d.osc;
    wire ramp_rise = cmp.ramp90 && !cmp_d.ramp90;
    wire sync_rise = cmp.sync && !cmp_d.sync;

    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    logic ctrl_enable;
    logic [3:0] irq_en;
    uhfs_pkg::uhfs_evt_t irq_stat;
    uhfs_pkg::uhfs_state_t state;
    uhfs_pkg::uhfs_state_t next_state;
    logic ramp_done;
    logic oc_in_cycle;
    logic oc_lockout;
    logic [3:0] blank_cnt;
    logic [2:0] off_cyc;
    logic [2:0] line_cnt;
    logic [2:0] fault_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Low-line detection
    // Ramp finished before this clock edge means a good line cycle
    wire low_line = cyc_start && !ramp_done && !ramp_rise;
    wire good_line = cyc_start && (ramp_done || ramp_rise);
    // Sync pulse cutting a ramp short is an immediate undervoltage
    wire sync_cut = sync_rise && !ramp_done && (state != uhfs_pkg::ST_LOCK);
    wire locked = (state == uhfs_pkg::ST_LOCK);
    // Locked: good cycles count up; once started the sense reverses
    wire line_inc = locked ? good_line : low_line;
    wire line_dec = locked ? low_line : good_line;
    wire line_full = (line_cnt == uhfs_pkg::CNT_SEVEN);
    wire start_ok = locked && line_full && ctrl_enable;
    wire uv_declare = (!locked && line_full) || sync_cut;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ramp_done <= 1'b0;
        end else if (cyc_start) begin
            ramp_done <= 1'b0;
        end else if (ramp_rise) begin
            ramp_done <= 1'b1;
        end
    end

    uhfs_satcnt #(
        .W(uhfs_pkg::CNT_W)
    ) u_line_cnt (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_clr(start_ok || uv_declare),
        .i_inc(line_inc),
        .i_dec(line_dec),
        .o_count(line_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Overcurrent, blanking and fault counting
    wire upper_on = o_upper_gate_drive;
    wire blanked = (blank_cnt != uhfs_pkg::BLANK_LAST);
    // Comparator is only meaningful while the upper gate is driven
    wire oc_hit = upper_on && !blanked && cmp.oc;
    wire running = (state == uhfs_pkg::ST_RUN);
    wire fault_inc = running && cyc_start && oc_in_cycle;
    wire fault_dec_run = running && cyc_start && !oc_in_cycle;
    wire off_wrap = (state == uhfs_pkg::ST_HICCUP) && cyc_start
                    && (off_cyc == uhfs_pkg::OFF_CYC_LAST);
    wire fault_full = (fault_cnt == uhfs_pkg::CNT_SEVEN);
    wire fault_zero = (fault_cnt == 3'h0);

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            blank_cnt <= 4'h0;
        end else if (!upper_on) begin
            blank_cnt <= 4'h0;
        end else if (blanked) begin
            blank_cnt <= blank_cnt + 4'h1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oc_in_cycle <= 1'b0;
            oc_lockout <= 1'b0;
        end else if (cyc_start) begin
            oc_in_cycle <= 1'b0;
            oc_lockout <= 1'b0;
        end else if (oc_hit) begin
            oc_in_cycle <= 1'b1;
            oc_lockout <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            off_cyc <= 3'h0;
        end else if (state != uhfs_pkg::ST_HICCUP) begin
            off_cyc <= 3'h0;
        end else if (cyc_start) begin
            off_cyc <= off_wrap ? 3'h0 : off_cyc + 3'h1;
        end
    end

    uhfs_satcnt #(
        .W(uhfs_pkg::CNT_W)
    ) u_fault_cnt (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_clr(locked),
        .i_inc(fault_inc),
        .i_dec(fault_dec_run || off_wrap),
        .o_count(fault_cnt)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            uhfs_pkg::ST_LOCK: begin
                if (start_ok) begin
                    next_state = uhfs_pkg::ST_RUN;
                end
            end
            uhfs_pkg::ST_RUN: begin
                if (uv_declare || !ctrl_enable) begin
                    next_state = uhfs_pkg::ST_LOCK;
                end else if (fault_full) begin
                    next_state = uhfs_pkg::ST_HICCUP;
                end
            end
            uhfs_pkg::ST_HICCUP: begin
                if (uv_declare || !ctrl_enable) begin
                    next_state = uhfs_pkg::ST_LOCK;
                end else if (fault_zero) begin
                    next_state = uhfs_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= uhfs_pkg::ST_LOCK;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gate drive and soft-start outputs
    // Switching is allowed only in run and only after the entry cycle,
    // so both switches are off when soft start begins.
    // No fresh on-pulse in the cycle whose start fills a counter: avoids a one-clock glitch
    wire fill_stop = (fault_inc && (fault_cnt == uhfs_pkg::CNT_SEVEN - 3'h1))
                     || (!locked && line_inc && (line_cnt == uhfs_pkg::CNT_SEVEN - 3'h1));
    wire may_switch = running && (next_state == uhfs_pkg::ST_RUN) && !fill_stop;
    wire pulse_end = cmp.pwm_end || oc_hit || oc_lockout;
    wire next_upper = may_switch && (cyc_start || (upper_on && !pulse_end));
    wire next_lower = may_switch && !next_upper && !cyc_start;
    wire next_ss = (next_state == uhfs_pkg::ST_RUN) && ctrl_enable;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_upper_gate_drive <= 1'b0;
            o_lower_gate_drive <= 1'b0;
            o_softstart_shutdown_node <= 1'b0;
            o_power_good <= 1'b0;
            o_ramp_restart <= 1'b0;
        end else begin
            o_upper_gate_drive <= next_upper;
            o_lower_gate_drive <= next_lower;
            o_softstart_shutdown_node <= next_ss;
            o_power_good <= (next_state != uhfs_pkg::ST_LOCK);
            o_ramp_restart <= cyc_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts
    uhfs_pkg::uhfs_evt_t evt;
    assign evt.hiccup = running && (next_state == uhfs_pkg::ST_HICCUP);
    assign evt.oc = oc_hit && !oc_in_cycle;
    assign evt.pg = start_ok;
    assign evt.uv = !locked && (next_state == uhfs_pkg::ST_LOCK);

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_ctrl = do_write && (aw_addr == uhfs_pkg::ADDR_CTRL);
    wire wr_clr = do_write && (aw_addr == uhfs_pkg::ADDR_IRQ_CLR);
    wire wr_en = do_write && (aw_addr == uhfs_pkg::ADDR_IRQ_EN);
    wire wr_ro = (aw_addr == uhfs_pkg::ADDR_STATUS) || (aw_addr == uhfs_pkg::ADDR_IRQ_STAT);
    wire wr_hit = wr_ctrl || wr_clr || wr_en || wr_ro;
    wire [3:0] clr_bits = wr_clr && w_strb[0] ? w_data[3:0] : 4'h0;
    // Hardware set wins over a clear in the same cycle
    wire [3:0] next_irq = (irq_stat & ~clr_bits) | evt;
    wire do_read = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {18'h0, fault_cnt, 1'b0, line_cnt, ramp_done,
                               oc_lockout, state, o_softstart_shutdown_node,
                               o_power_good, o_upper_gate_drive};
    wire rd_hit = (s_axi_araddr == uhfs_pkg::ADDR_CTRL)
                  || (s_axi_araddr == uhfs_pkg::ADDR_STATUS)
                  || (s_axi_araddr == uhfs_pkg::ADDR_IRQ_STAT)
                  || (s_axi_araddr == uhfs_pkg::ADDR_IRQ_CLR)
                  || (s_axi_araddr == uhfs_pkg::ADDR_IRQ_EN);
    wire [31:0] rd_word =
        (s_axi_araddr == uhfs_pkg::ADDR_CTRL) ? {31'h0, ctrl_enable} :
        (s_axi_araddr == uhfs_pkg::ADDR_STATUS) ? status_word :
        (s_axi_araddr == uhfs_pkg::ADDR_IRQ_STAT) ? {28'h0, irq_stat} :
        (s_axi_araddr == uhfs_pkg::ADDR_IRQ_EN) ? {28'h0, irq_en} : 32'h0;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= uhfs_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? uhfs_pkg::RESP_OKAY : uhfs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= uhfs_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !do_read;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? uhfs_pkg::RESP_OKAY : uhfs_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_enable <= uhfs_pkg::CTRL_RESET;
            irq_en <= uhfs_pkg::IRQ_EN_RESET;
            irq_stat <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr_ctrl && w_strb[0]) begin
                ctrl_enable <= w_data[0];
            end
            if (wr_en && w_strb[0]) begin
                irq_en <= w_data[3:0];
            end
            irq_stat <= next_irq;
            o_irq <= |(next_irq & irq_en);
        end
    end
endmodule
`default_nettype wire

// [uhfs_top_properties.sv]
// Port-level checks of the protection sequencer, bound into uhfs_top.
// Assumes a single i_ref_clk domain and asynchronous active-low i_nrst.
`timescale 1ns/1ns
`default_nettype none
module uhfs_top_properties (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_overcurrent_trip,
    input wire logic i_pwm_duty_end,
    input wire logic o_upper_gate_drive,
    input wire logic o_lower_gate_drive,
    input wire logic o_softstart_shutdown_node,
    input wire logic o_power_good,
    input wire logic o_ramp_restart
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    logic [4:0] oc_run;
    // Blanking plus synchroniser latency stays well under 20 clocks
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oc_run <= 5'h00;
        end else if (o_upper_gate_drive && i_overcurrent_trip && oc_run != 5'h1F) begin
            oc_run <= oc_run + 5'h01;
        end else if (!(o_upper_gate_drive && i_overcurrent_trip)) begin
            oc_run <= 5'h00;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_pg_start_off: assert property ($rose(o_power_good) |-> o_softstart_shutdown_node
        && !o_upper_gate_drive && !o_lower_gate_drive) else $error("start not clean");
    a_ss_needs_pg: assert property (o_softstart_shutdown_node |-> o_power_good)
        else $error("soft start released while locked out");
    a_ss_low_gates: assert property (!o_softstart_shutdown_node |->
        !o_upper_gate_drive && !o_lower_gate_drive) else $error("gate on with soft start low");
    a_uv_gates_off: assert property (!o_power_good |->
        !o_upper_gate_drive && !o_lower_gate_drive) else $error("gate on in lockout");
    a_restart_single: assert property ($rose(o_ramp_restart) |=> !o_ramp_restart[*8])
        else $error("ramp restart not a single pulse");
    a_upper_at_start: assert property ($rose(o_upper_gate_drive) |-> o_ramp_restart
        || $past(o_ramp_restart) || $past(o_ramp_restart, 2)) else $error("upper on mid-cycle");
    a_oc_blank: assert property ($rose(o_upper_gate_drive) && !i_pwm_duty_end
        |-> o_upper_gate_drive[*8]) else $error("on-pulse cut inside blanking");
    a_oc_cuts_pulse: assert property (oc_run < 5'd20)
        else $error("overcurrent did not end the pulse");
endmodule
bind uhfs_top uhfs_top_properties i_uhfs_top_properties (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_overcurrent_trip(i_overcurrent_trip),
    .i_pwm_duty_end(i_pwm_duty_end),
    .o_upper_gate_drive(o_upper_gate_drive),
    .o_lower_gate_drive(o_lower_gate_drive),
    .o_softstart_shutdown_node(o_softstart_shutdown_node),
    .o_power_good(o_power_good),
    .o_ramp_restart(o_ramp_restart)
);
`default_nettype wire

// [uhfs_top_tb_top.sv]
// Self-checking bench of the protection sequencer and its register file.
// Assumes the comparator model in uhfs_cmp_model and a 100 MHz reference clock.
`timescale 1ns/1ns
`default_nettype none
module uhfs_top_tb_top;
    logic clk = 1'b0, nrst = 1'b0, good = 1'b0, oc_on = 1'b0, ext_sync = 1'b0;
    logic osc, ramp90, oc, pwm_end, upper, lower, ss, pg, rr, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    int fails = 0, checks = 0, n;
    always #5 clk = ~clk;
    uhfs_cmp_model i_uhfs_cmp_model (.i_ref_clk(clk), .i_nrst(nrst), .i_upper_gate_drive(upper),
        .i_good(good), .i_oc_on(oc_on), .o_osc(osc), .o_ramp90(ramp90), .o_oc(oc),
        .o_pwm_end(pwm_end));
    uhfs_top i_uhfs_top (.i_ref_clk(clk), .i_nrst(nrst), .i_osc_clk_pulse(osc),
        .i_ramp_at_90pct(ramp90), .i_ext_sync_pulse(ext_sync), .i_overcurrent_trip(oc),
        .i_pwm_duty_end(pwm_end), .o_upper_gate_drive(upper), .o_lower_gate_drive(lower),
        .o_softstart_shutdown_node(ss), .o_power_good(pg), .o_ramp_restart(rr), .o_irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, dd;
        ad = 0;
        dd = 0;
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (awready === 1'b1 && !ad) begin ad = 1; awvalid <= 1'b0; end
            if (wready === 1'b1 && !dd) begin dd = 1; wvalid <= 1'b0; end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic wait_start();
        do @(negedge clk); while (rr !== 1'b1);
    endtask
    // Counts restart pulses, or upper gate falls, until pg or ss reaches lvl
    task automatic count_to(input bit falls, input bit on_ss, input logic lvl, output int c);
        logic prev;
        c = 0;
        prev = upper;
        while ((on_ss ? ss : pg) !== lvl) begin
            @(negedge clk);
            if (falls ? (prev === 1'b1 && upper === 1'b0) : (rr === 1'b1)) c++;
            prev = upper;
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("pg at reset", pg, 1'b0);
        chk("ss at reset", ss, 1'b0);
        axr(uhfs_pkg::ADDR_CTRL, rd, resp);
        chk("ctrl reset", rd[0], uhfs_pkg::CTRL_RESET);
        axr(uhfs_pkg::ADDR_IRQ_EN, rd, resp);
        chk("irq_en reset", rd[3:0], uhfs_pkg::IRQ_EN_RESET);
        axr(8'h40, rd, resp);
        chk("unmapped read resp", resp, uhfs_pkg::RESP_SLVERR);
        chk("unmapped read data", rd, 32'h0000_0000);
        $display("test reset done");
    endtask
    task automatic t_start();
        repeat (3) wait_start();
        @(posedge clk) good <= 1'b1;
        count_to(0, 0, 1'b1, n);
        chk("good cycles to power good", n, 7);
        chk("soft start released", ss, 1'b1);
        $display("test start done");
    endtask
    task automatic t_lowline();
        wait_start();
        @(posedge clk) good <= 1'b0;
        count_to(0, 0, 1'b0, n);
        chk("low-line cycles to lockout", n, 7);
        repeat (2) @(negedge clk);
        chk("ss held low", ss, 1'b0);
        chk("gates off", {upper, lower}, 2'b00);
        $display("test lowline done");
    endtask
    task automatic t_hiccup(input bit check_len);
        wait_start();
        @(posedge clk) oc_on <= 1'b1;
        count_to(1, 1, 1'b0, n);
        chk("oc pulses to hiccup", n, 7);
        chk("gates off in hiccup", {upper, lower}, 2'b00);
        @(posedge clk) oc_on <= 1'b0;
        count_to(0, 1, 1'b1, n);
        if (check_len) chk("restart cycles", n, 49);
        $display("test hiccup done");
    endtask
    task automatic t_regs();
        axr(uhfs_pkg::ADDR_IRQ_STAT, rd, resp);
        chk("irq status", rd, 32'h0000_000F);
        chk("irq masked", irq, 1'b0);
        axw(uhfs_pkg::ADDR_IRQ_EN, 32'h0000_0008, resp);
        chk("irq_en write resp", resp, uhfs_pkg::RESP_OKAY);
        repeat (2) @(negedge clk);
        chk("irq raised", irq, 1'b1);
        axw(uhfs_pkg::ADDR_IRQ_CLR, 32'h0000_000F, resp);
        repeat (2) @(negedge clk);
        chk("irq cleared", irq, 1'b0);
        axr(uhfs_pkg::ADDR_IRQ_STAT, rd, resp);
        chk("irq status cleared", rd, 32'h0000_0000);
        axr(uhfs_pkg::ADDR_IRQ_CLR, rd, resp);
        chk("clear reads zero", rd, 32'h0000_0000);
        axw(8'h40, 32'h0000_0001, resp);
        chk("unmapped write resp", resp, uhfs_pkg::RESP_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_ctrl_sync();
        wait_start();
        repeat (15) @(negedge clk);
        axw(uhfs_pkg::ADDR_CTRL, 32'h0000_0000, resp);
        repeat (3) @(negedge clk);
        chk("disable forces lockout", pg, 1'b0);
        axw(uhfs_pkg::ADDR_CTRL, 32'h0000_0001, resp);
        count_to(0, 0, 1'b1, n);
        wait_start();
        @(posedge clk) ext_sync <= 1'b1;
        repeat (6) @(posedge clk);
        ext_sync <= 1'b0;
        repeat (10) @(negedge clk);
        chk("sync before ramp done", pg, 1'b0);
        chk("gates off after sync", {upper, lower}, 2'b00);
        $display("test ctrl_sync done");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_start();
        t_lowline();
        t_start();
        t_hiccup(1);
        t_hiccup(0);
        t_regs();
        t_ctrl_sync();
        close_out();
    end
    initial begin
        #500_000;
        fails++;
        close_out();
    end
endmodule
`default_nettype wire
